/* tb/wqo_queue_cfg_props.sv */
`timescale 1ns/1ps
// ------------------------------
// Port checks of the queue block
// ------------------------------
module wqo_queue_cfg_props
	import wqo_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// Observed ports
	input wire wqo_req_t   req,
	input wire logic       rvalid,
	input wire logic       cap_occ_int,
	input wire logic       cmd_enable,
	input wire logic       cmd_drain,
	input wire logic       submit,
	input wire logic       submit_queued,
	input wire logic       accept,
	input wire logic       retry,
	input wire logic       op_refused,
	input wire wqo_state_t state,
	input wire wqo_irq_t   irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_RD_ANSWER: assert property (req.rd |=> rvalid)
		else $error("read not answered");
	AST_DIS_NO_ACCEPT: assert property (submit && state != WQO_ST_ENABLED |=> !accept)
		else $error("accept while not enabled");
	AST_QUEUED_RETRY: assert property (submit && submit_queued && state != WQO_ST_ENABLED |=> retry)
		else $error("queued write not retried");
	AST_EN_NO_RETRY: assert property (submit && state == WQO_ST_ENABLED |=> !retry)
		else $error("retry while enabled");
	AST_IRQ_ONCE: assert property (irq.valid |=> !irq.valid)
		else $error("second interrupt before flag clear");
	AST_ACCEPT_CAUSE: assert property (accept || op_refused |-> $past(submit))
		else $error("answer without a submission");
	AST_REFUSE_ALONE: assert property (op_refused |-> !accept && !retry)
		else $error("refused operation also accepted");
	AST_ENABLE_CMD: assert property (cmd_enable && state == WQO_ST_DISABLED |=> state == WQO_ST_ENABLED)
		else $error("enable command ignored");
	AST_DRAIN_CMD: assert property (cmd_drain && state == WQO_ST_ENABLED |=> state != WQO_ST_ENABLED)
		else $error("drain command ignored");
	AST_IRQ_WHEN_ENABLED: assert property (irq.valid |-> $past(state) == WQO_ST_ENABLED)
		else $error("interrupt from a queue that was not enabled");
	AST_IRQ_NEEDS_CAP: assert property (!cap_occ_int |=> !irq.valid)
		else $error("interrupt without occupancy interrupt support");
endmodule : wqo_queue_cfg_props
bind wqo_queue_cfg wqo_queue_cfg_props wqo_queue_cfg_props_i (.clk, .rst_n, .req, .rvalid, .cap_occ_int, .cmd_enable,
	.cmd_drain, .submit, .submit_queued, .accept, .retry, .op_refused, .state, .irq);

/* tb/wqo_queue_cfg_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin failures++; $display("Error %s exp %h got %h", n, e, a); end end
// ------------------------------
// Queue config block bench
// ------------------------------
module wqo_queue_cfg_tb import wqo_pkg::*;;
	logic        clk, rst_n, cap_occ_int, cap_occ, cap_config, mode_support;
	logic        cmd_enable, cmd_drain, submit, submit_queued, dispatch;
	logic        accept, retry, op_refused, rvalid;
	logic [7:0]  submit_opcode;
	logic [31:0] rdata;
	wqo_req_t    req;
	wqo_state_t  state;
	wqo_irq_t    irq, irq_seen;
	int          failures, checks_done, irq_cnt;
	// Top opcodes left undefined so unused mask bits can be seen
	wqo_queue_cfg #(.DEFINED_OPS({32'h0000_FFFF, {224{1'b1}}})) wqo_queue_cfg_i (.clk, .rst_n, .req, .rdata,
		.rvalid, .cap_occ_int, .cap_occ, .cap_config, .mode_support, .cmd_enable, .cmd_drain, .submit,
		.submit_queued, .submit_opcode, .dispatch, .accept, .retry, .op_refused, .state, .irq);
	// Clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Count interrupt messages, keep the last one; looked at mid-cycle where irq has settled
	always @(negedge clk) begin
		if (irq.valid === 1'b1) begin
			irq_cnt++;
			irq_seen = irq;
		end
	end
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		req = '0;
	endtask : wr
	// Registered answer is checked one cycle after the request is driven
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk);
		req = '{1'b0, 1'b1, a, 32'h0};
		@(negedge clk);
		req = '0;
		`CHK("rdata", {1'b1, e}, {rvalid, rdata})
	endtask : rd
	task sub(input logic q, input logic [7:0] op, input logic [2:0] e);
		@(negedge clk);
		{submit, submit_queued, submit_opcode} = {1'b1, q, op};
		@(negedge clk);
		submit = 1'b0;
		`CHK("descriptor answer", e, {accept, retry, op_refused})
	endtask : sub
	task stop_test;
		if (failures == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		stop_test();
	end
	// Main sequence
	initial begin
		{rst_n, cap_occ_int, cap_occ, cap_config, mode_support} = 5'b01101;
		{cmd_enable, cmd_drain, submit, submit_queued, dispatch, submit_opcode} = '0;
		req = '0;
		{failures, checks_done, irq_cnt} = '0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		rd(8'h18, 32'h2000_0000);
		rd(8'h1C, 32'h0000_0000);
		rd(8'h44, 32'h0000_0000);
		wr(8'h10, 32'h0001_0ABC);
		wr(8'h20, 32'hFFFF_FFF7);
		wr(8'h3C, 32'hFFFF_FFFF);
		rd(8'h20, 32'hFFFF_FFF7);
		rd(8'h3C, 32'h0000_FFFF);
		sub(1'b1, 8'h00, 3'b010);
		sub(1'b0, 8'h00, 3'b000);
		wr(8'h14, 32'h0001_0000);
		cyc(4);
		`CHK("irq count", 0, irq_cnt)
		pulse(cmd_enable);
		cyc(4);
		`CHK("irq count", 1, irq_cnt)
		`CHK("irq message", 18'h3_0ABC, irq_seen)
		rd(8'h18, 32'h6001_0000);
		sub(1'b0, 8'h01, 3'b100);
		sub(1'b0, 8'h03, 3'b001);
		sub(1'b1, 8'h02, 3'b100);
		wr(8'h14, 32'h0000_0005);
		wr(8'h14, 32'h0001_0001);
		rd(8'h14, 32'h0001_0001);
		wr(8'h14, 32'h0001_0007);
		rd(8'h14, 32'h0001_0001);
		wr(8'h18, 32'h0001_0000);
		rd(8'h18, 32'h6000_0002);
		`CHK("irq count", 1, irq_cnt)
		pulse(dispatch);
		cyc(4);
		`CHK("irq count", 2, irq_cnt)
		rd(8'h18, 32'h6001_0001);
		pulse(cmd_drain);
		sub(1'b1, 8'h01, 3'b010);
		rd(8'h18, 32'hA001_0001);
		pulse(dispatch);
		cyc(2);
		rd(8'h18, 32'h2001_0000);
		`CHK("state", WQO_ST_DISABLED, state)
		// Without occupancy interrupt support its words are reserved and read zero
		cap_occ_int = 1'b0;
		wr(8'h14, 32'h0000_0003);
		rd(8'h14, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		// With configuration support the mode-support bit is unused and reads zero
		cap_config = 1'b1;
		rd(8'h18, 32'h0001_0000);
		stop_test();
	end
endmodule : wqo_queue_cfg_tb

/* verilog/wqo_pkg.sv */
package wqo_pkg;

	// Two-bit queue state as software reads it
	typedef enum logic [1:0] {
		WQO_ST_DISABLED = 2'h0,
		WQO_ST_ENABLED  = 2'h1,
		WQO_ST_DRAINING = 2'h2
	} wqo_state_t;

	// Register access request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} wqo_req_t;

	// Occupancy interrupt message toward the table logic
	typedef struct packed {
		logic        valid;
		logic        ims_sel;
		logic [15:0] handle;
	} wqo_irq_t;

endpackage : wqo_pkg

/* verilog/wqo_queue_cfg.sv */
`timescale 1ns/1ps
`include "wqo_regs.svh"
// Overview of operation
// - Enable set and occupancy at or below limit raises an interrupt.
// - Raising the interrupt sets the interrupt-generated flag.
// - Setting enable with limit already >= occupancy interrupts at once.
// - Enable set while queue disabled holds delivery until queue enabled.
// - One write may set enable and load a new limit together.
// - Limit is read-only while enable is 1, except in the enabling write.
// - No interrupt support makes enable and limit reserved.
// - Disabled state refuses descriptors: queued writes retry, others ignored.
// - Enabled state accepts submitted descriptors with an allowed opcode and processes them.
// - Commands in progress report state 10, refuse and drain; 11 unused.
// - Writing 1 clears the flag; no new interrupt until it is clear.
// - Read-only count of entries, tracking submissions and dispatches.
// - Without occupancy support the count reads as zero.
// - 256-bit mask allows an operation code when its bit is 1.
// - Mask bits of undefined operation codes are unused and read zero.
// - Mode-support bit flags read-only fields when configuration unsupported.
// - Interrupt goes through the table entry named by the 16-bit handle.
// - Table-select bit: 0 standard table, 1 interrupt message store.
module wqo_queue_cfg
	import wqo_pkg::*;
#(
	parameter logic [255:0] DEFINED_OPS = {256{1'b1}}
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Register access
	input  wire wqo_req_t    req,
	output logic [31:0]      rdata,
	output logic             rvalid,
	// Capabilities
	input  wire logic        cap_occ_int,
	input  wire logic        cap_occ,
	input  wire logic        cap_config,
	input  wire logic        mode_support,
	// Queue control commands
	input  wire logic        cmd_enable,
	input  wire logic        cmd_drain,
	// Descriptor path
	input  wire logic        submit,
	input  wire logic        submit_queued,
	input  wire logic [7:0]  submit_opcode,
	input  wire logic        dispatch,
	output logic             accept,
	output logic             retry,
	output logic             op_refused,
	// Queue status and interrupt
	output wqo_state_t       state,
	output wqo_irq_t         irq
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	wqo_state_t   state_reg,   state_next;
	logic         en_reg,      en_next;
	logic [15:0]  limit_reg,   limit_next;
	logic         gen_reg,     gen_next;
	logic         sel_reg,     sel_next;
	logic [15:0]  handle_reg,  handle_next;
	logic [15:0]  occ_reg,     occ_next;
	logic [31:0]  mask_reg [0:7];
	logic [31:0]  mask_next [0:7];
	logic [31:0]  rdata_reg,   rdata_next;
	logic         rvalid_reg,  rvalid_next;
	logic         accept_reg,  accept_next;
	logic         retry_reg,   retry_next;
	logic         refused_reg, refused_next;
	wqo_irq_t     irq_reg,     irq_next;

	// Word select helper, used by read and write decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// Index of a mask word for an address, valid only within the mask window
	function automatic logic [2:0] mask_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - `WQO_OFF_OPMASK;
		mask_idx = d[4:2];
	endfunction : mask_idx

	logic in_mask;
	logic mask_bit;
	logic can_fire;
	logic [15:0] occ_calc;
	logic do_acc;

	// ----------------------------------------------------------------
	// Queue state
	// ----------------------------------------------------------------
	// Draining waits for the last entry to leave, so software never sees
	// a disabled queue that still holds work
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			WQO_ST_DISABLED: begin
				if (cmd_enable)
					state_next = WQO_ST_ENABLED;
			end
			WQO_ST_ENABLED: begin
				if (cmd_drain)
					state_next = WQO_ST_DRAINING;
			end
			WQO_ST_DRAINING: begin
				if (occ_reg == 16'h0000)
					state_next = WQO_ST_DISABLED;
			end
			// Code 11 is never entered; a stray value falls back to disabled
			default: state_next = WQO_ST_DISABLED;
		endcase
	end

	// Queue state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= WQO_ST_DISABLED;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Descriptor path and occupancy
	// ----------------------------------------------------------------
	// Only an enabled queue takes work, and only for allowed operation codes
	always_comb begin
		retry_next   = 1'b0;
		refused_next = 1'b0;
		do_acc       = 1'b0;
		mask_bit     = mask_reg[submit_opcode[7:5]][submit_opcode[4:0]];
		// A queued writer is told to retry; a plain write to a closed queue is dropped
		if (submit) begin
			if (state_reg == WQO_ST_ENABLED) begin
				if (mask_bit)
					do_acc = 1'b1;
				else
					refused_next = 1'b1;
			end else if (submit_queued) begin
				retry_next = 1'b1;
			end
		end
		accept_next = do_acc;
		// Accept and dispatch together cancel unless the queue is empty; an empty queue never wraps below zero
		occ_calc = occ_reg;
		if (do_acc && !(dispatch && occ_reg != 16'h0000))
			occ_calc = occ_reg + 16'h0001;
		else if (!do_acc && dispatch && occ_reg != 16'h0000)
			occ_calc = occ_reg - 16'h0001;
		occ_next = occ_calc;
	end

	// Occupancy count and descriptor answers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			occ_reg     <= `WQO_RST_OCC;
			accept_reg  <= 1'b0;
			retry_reg   <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			occ_reg     <= occ_next;
			accept_reg  <= accept_next;
			retry_reg   <= retry_next;
			refused_reg <= refused_next;
		end
	end

	// ----------------------------------------------------------------
	// Configuration writes
	// ----------------------------------------------------------------
	// The limit moves only while enable was clear before the write, which
	// also lets one write load the limit and set enable together
	always_comb begin
		en_next     = en_reg;
		limit_next  = limit_reg;
		sel_next    = sel_reg;
		handle_next = handle_reg;
		for (int i = 0; i < `WQO_OPMASK_WORDS; i++) begin
			mask_next[i] = mask_reg[i];
		end
		in_mask = (req.addr >= `WQO_OFF_OPMASK) && (req.addr < 8'h40);
		if (req.wr) begin
			// Handle and table select are locked once the queue leaves disabled
			if (hit(req.addr, `WQO_OFF_HANDLE) && state_reg == WQO_ST_DISABLED) begin
				handle_next = req.wdata[15:0];
				sel_next    = cap_occ_int & req.wdata[`WQO_BIT_TABLE_SEL];
			end
			if (hit(req.addr, `WQO_OFF_INT_CTRL) && cap_occ_int) begin
				en_next = req.wdata[`WQO_BIT_INT_EN];
				if (!en_reg)
					limit_next = req.wdata[15:0];
			end
			// Mask words change only while the queue cannot be taking work
			if (in_mask && state_reg == WQO_ST_DISABLED) begin
				for (int i = 0; i < `WQO_OPMASK_WORDS; i++) begin
					if (mask_idx(req.addr) == i[2:0])
						mask_next[i] = req.wdata & DEFINED_OPS[i*32 +: 32];
				end
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_reg     <= 1'b0;
			limit_reg  <= `WQO_RST_LIMIT;
			sel_reg    <= 1'b0;
			handle_reg <= `WQO_RST_HANDLE;
			for (int i = 0; i < `WQO_OPMASK_WORDS; i++) begin
				mask_reg[i] <= 32'h0000_0000;
			end
		end else begin
			en_reg     <= en_next;
			limit_reg  <= limit_next;
			sel_reg    <= sel_next;
			handle_reg <= handle_next;
			for (int i = 0; i < `WQO_OPMASK_WORDS; i++) begin
				mask_reg[i] <= mask_next[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Occupancy interrupt
	// ----------------------------------------------------------------
	// Fire from the new occupancy, enable and limit, so an enabling write with
	// the limit already reached fires at once; a disabled queue holds off.
	// A clear meeting a due interrupt: the old flag still blocks, it fires next cycle
	always_comb begin
		gen_next = gen_reg;
		irq_next = '0;
		if (req.wr && hit(req.addr, `WQO_OFF_STATE_OCC) && req.wdata[`WQO_BIT_INT_GEN])
			gen_next = 1'b0;
		can_fire = en_next && (occ_calc <= limit_next) && !gen_reg
			&& (state_reg == WQO_ST_ENABLED) && cap_occ_int;
		if (can_fire) begin
			gen_next         = 1'b1;
			irq_next.valid   = 1'b1;
			irq_next.ims_sel = sel_reg;
			irq_next.handle  = handle_reg;
		end
	end

	// Interrupt-generated flag and interrupt message
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gen_reg <= 1'b0;
			irq_reg <= '0;
		end else begin
			gen_reg <= gen_next;
			irq_reg <= irq_next;
		end
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	// Unmapped and reserved words read zero, and data is zero outside rvalid
	always_comb begin
		rdata_next  = 32'h0000_0000;
		rvalid_next = req.rd;
		if (req.rd) begin
			if (hit(req.addr, `WQO_OFF_HANDLE) && cap_occ_int)
				rdata_next = {15'h0000, sel_reg, handle_reg};
			else if (hit(req.addr, `WQO_OFF_INT_CTRL) && cap_occ_int)
				rdata_next = {15'h0000, en_reg, limit_reg};
			else if (hit(req.addr, `WQO_OFF_STATE_OCC)) begin
				rdata_next[`WQO_STATE_HI:`WQO_STATE_LO] = state_reg;
				rdata_next[`WQO_BIT_MODE_SUP] = !cap_config && mode_support;
				rdata_next[`WQO_BIT_INT_GEN]  = gen_reg;
				rdata_next[15:0] = cap_occ ? occ_reg : 16'h0000;
			end else if (in_mask)
				// Mask bits of undefined operation codes always read zero
				rdata_next = mask_reg[mask_idx(req.addr)] & DEFINED_OPS[mask_idx(req.addr)*32 +: 32];
		end
	end

	// Read data and its valid pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg  <= 32'h0000_0000;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Outputs straight from flops
	assign rdata      = rdata_reg;
	assign rvalid     = rvalid_reg;
	assign accept     = accept_reg;
	assign retry      = retry_reg;
	assign op_refused = refused_reg;
	assign state      = state_reg;
	assign irq        = irq_reg;

endmodule : wqo_queue_cfg

/* verilog/wqo_regs.svh */
`ifndef WQO_REGS_SVH
`define WQO_REGS_SVH

// ----------------------------------------------------------------
// Register offsets within one queue's configuration entry
// ----------------------------------------------------------------
`define WQO_OFF_HANDLE     8'h10
`define WQO_OFF_INT_CTRL   8'h14
`define WQO_OFF_STATE_OCC  8'h18
`define WQO_OFF_RSVD       8'h1C
`define WQO_OFF_OPMASK     8'h20
`define WQO_OPMASK_WORDS   8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WQO_BIT_TABLE_SEL  16
`define WQO_BIT_INT_EN     16
`define WQO_BIT_INT_GEN    16
`define WQO_BIT_MODE_SUP   29
`define WQO_STATE_HI       31
`define WQO_STATE_LO       30

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WQO_RST_LIMIT      16'h0000
`define WQO_RST_HANDLE     16'h0000
`define WQO_RST_OCC        16'h0000

`endif
